//--- core/nand_tgt_pkg.sv
// Constants shared by the target busy, protect and bus-width support logic
// Notes on behaviour
// (RQ1) All targets share one bus width, 8 or 16; double-rate parts are 8-bit only.
// (RQ2) On a 16-bit bus only data uses full width; command and address use low byte.
// (RQ3) Upper byte lane is ignored during command cycles on a 16-bit bus.
// (RQ4) Host drives the upper byte lane to zero during address cycles.
// (RQ5) Busy output is the AND of every logical unit ready status bit.
// (RQ6) Busy output becomes valid within 10 us, or 250 us with a controller.
// (RQ7) Busy output reaches ready within 1 ms, or 2 ms with a controller.
// (RQ8) Host must not sample busy until 50 us after supply ramp plus validity delay.
// (RQ9) With eight enables and four busy pins, enables 0 and 2, 1 and 3 share; the code pairs enable b with enable b+4 instead.
// (RQ10) Busy output is open drain: drive low or release only.
// (RQ11) Program and erase are refused while write protect is low.
// (RQ12) Host changes write protect only while no command executes.
// (RQ13) Host keeps bus idle for the protect settle time after write protect changes.
// (RQ14) Write protect is asynchronous and is synchronised internally.
// (RQ15) Target stays in low power until its first reset command.
// (RQ16) Logical unit ready bit is one when idle, zero during array operations.
package nand_tgt_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLOCK_MHZ = 200;
  localparam int VALID_DELAY_US_RAW = 10;
  localparam int VALID_DELAY_US_CTRL = 250;
  localparam int READY_TIME_MS_RAW = 1;
  localparam int READY_TIME_MS_CTRL = 2;
  localparam int VALID_CYC_RAW = VALID_DELAY_US_RAW * CLOCK_MHZ;
  localparam int VALID_CYC_CTRL = VALID_DELAY_US_CTRL * CLOCK_MHZ;
  localparam int READY_CYC_RAW = READY_TIME_MS_RAW * 1000 * CLOCK_MHZ;
  localparam int READY_CYC_CTRL = READY_TIME_MS_CTRL * 1000 * CLOCK_MHZ;
  localparam int TIMER_W = 20;

  // ****************************************
  // Bus and commands
  // ****************************************
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_PROG_FIRST = 8'h80;
  localparam logic [7:0] CMD_ERASE_FIRST = 8'h60;
  localparam int NUM_ENABLES = 8;
  localparam int NUM_BUSY = 4;

  typedef enum logic [1:0] {
    ST_UNDEFINED,
    ST_VALID_BUSY,
    ST_READY
  } pwr_state_e;

endpackage

//--- core/nand_busy_timer.sv
// Power-on timer that releases the busy output after the validity and ready delays
module nand_busy_timer #(
  parameter int VALID_CYC = nand_tgt_pkg::VALID_CYC_RAW,
  parameter int READY_CYC = nand_tgt_pkg::READY_CYC_RAW
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  output logic o_valid,
  output logic o_ready
);

  nand_tgt_pkg::pwr_state_e state_q, state_d;
  logic [nand_tgt_pkg::TIMER_W-1:0] count_q, count_d;

  always_comb begin
    state_d = state_q;
    count_d = count_q + 1'b1;
    case (state_q)
      nand_tgt_pkg::ST_UNDEFINED: begin
        if (count_q == nand_tgt_pkg::TIMER_W'(VALID_CYC - 1)) begin // RQ6
          state_d = nand_tgt_pkg::ST_VALID_BUSY;
        end
      end
      nand_tgt_pkg::ST_VALID_BUSY: begin
        if (count_q == nand_tgt_pkg::TIMER_W'(READY_CYC - 1)) begin // RQ7
          state_d = nand_tgt_pkg::ST_READY;
        end
      end
      default: begin
        count_d = count_q;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= nand_tgt_pkg::ST_UNDEFINED;
      count_q <= '0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  assign o_valid = (state_q != nand_tgt_pkg::ST_UNDEFINED);
  assign o_ready = (state_q == nand_tgt_pkg::ST_READY);

endmodule

//--- core/nand_target_support.sv
// Target busy aggregation, write-protect gating, bus-width and low-power control
module nand_target_support #(
  parameter int LUNS = 2,
  parameter bit WIDE_BUS = 1'b0,
  parameter bit DOUBLE_RATE = 1'b0,
  parameter bit INTEGRATED_CTRL = 1'b0,
  parameter int VALID_CYC = INTEGRATED_CTRL ? nand_tgt_pkg::VALID_CYC_CTRL
                                            : nand_tgt_pkg::VALID_CYC_RAW,
  parameter int READY_CYC = INTEGRATED_CTRL ? nand_tgt_pkg::READY_CYC_CTRL
                                            : nand_tgt_pkg::READY_CYC_RAW
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_wp_b,
  input wire logic [nand_tgt_pkg::NUM_ENABLES-1:0] i_lun_ready_status_bit,
  input wire logic [LUNS-1:0] i_unit_ready,
  input wire logic i_cmd_strobe,
  input wire logic i_addr_strobe,
  input wire logic i_data_strobe,
  input wire logic [15:0] i_bus,
  output logic [nand_tgt_pkg::NUM_BUSY-1:0] o_busy_pin_oe,
  output logic [nand_tgt_pkg::NUM_BUSY-1:0] o_busy_pin_out,
  output logic o_busy_oe,
  output logic o_busy_out,
  output logic o_low_power,
  output logic [7:0] o_cmd,
  output logic o_cmd_valid,
  output logic [7:0] o_addr,
  output logic o_addr_valid,
  output logic [15:0] o_data,
  output logic o_data_valid,
  output logic o_array_op_allowed,
  output logic o_op_refused
);

  // ****************************************
  // Configuration check
  // ****************************************
  if (DOUBLE_RATE && WIDE_BUS) begin : g_bad_width
    $error("double rate interface needs an 8-bit bus"); // RQ1
  end

  // ****************************************
  // Power-on timing
  // ****************************************
  logic timer_ready;

  nand_busy_timer #(
    .VALID_CYC(VALID_CYC),
    .READY_CYC(READY_CYC)
  ) u_timer (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .o_valid(),
    .o_ready(timer_ready)
  );

  // ****************************************
  // Write-protect synchroniser
  // ****************************************
  logic wp_meta_q, wp_sync_q;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wp_meta_q <= 1'b0;
      wp_sync_q <= 1'b0;
    end else begin
      wp_meta_q <= i_wp_b; // RQ14
      wp_sync_q <= wp_meta_q;
    end
  end

  // ****************************************
  // Bus decode and gating
  // ****************************************
  logic low_power_q, low_power_d;
  logic [7:0] cmd_q, cmd_d, addr_q, addr_d;
  logic [15:0] data_q, data_d;
  logic cmd_valid_q, cmd_valid_d, addr_valid_q, addr_valid_d;
  logic data_valid_q, data_valid_d, refused_q, refused_d, allowed_q, allowed_d;

  function automatic logic is_array_write(input logic [7:0] c);
    is_array_write = (c == nand_tgt_pkg::CMD_PROG_FIRST) ||
                     (c == nand_tgt_pkg::CMD_ERASE_FIRST);
  endfunction

  always_comb begin
    low_power_d = low_power_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    data_d = data_q;
    cmd_valid_d = 1'b0;
    addr_valid_d = 1'b0;
    data_valid_d = 1'b0;
    refused_d = 1'b0;
    allowed_d = wp_sync_q; // RQ11
    if (i_cmd_strobe) begin
      cmd_d = i_bus[7:0]; // RQ2 RQ3
      if (i_bus[7:0] == nand_tgt_pkg::CMD_RESET) begin
        low_power_d = 1'b0; // RQ15
      end
      // Refuse on the same level that is shown on o_array_op_allowed
      if (is_array_write(i_bus[7:0]) && !allowed_q) begin
        refused_d = 1'b1; // RQ11
      end else begin
        cmd_valid_d = 1'b1;
      end
    end else if (i_addr_strobe) begin
      addr_d = i_bus[7:0]; // RQ2
      addr_valid_d = 1'b1;
    end else if (i_data_strobe) begin
      data_d = WIDE_BUS ? i_bus : {8'h00, i_bus[7:0]}; // RQ1
      data_valid_d = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      low_power_q <= 1'b1;
      cmd_q <= 8'h00;
      addr_q <= 8'h00;
      data_q <= 16'h0000;
      cmd_valid_q <= 1'b0;
      addr_valid_q <= 1'b0;
      data_valid_q <= 1'b0;
      refused_q <= 1'b0;
      allowed_q <= 1'b0;
    end else begin
      low_power_q <= low_power_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      data_q <= data_d;
      cmd_valid_q <= cmd_valid_d;
      addr_valid_q <= addr_valid_d;
      data_valid_q <= data_valid_d;
      refused_q <= refused_d;
      allowed_q <= allowed_d;
    end
  end

  // ****************************************
  // Busy outputs
  // ****************************************
  logic busy_oe_q, busy_oe_d;
  logic [nand_tgt_pkg::NUM_BUSY-1:0] pin_oe_q, pin_oe_d;

  always_comb begin
    busy_oe_d = !(timer_ready && (&i_unit_ready)); // RQ5 RQ7 RQ16
    // Enables b and b+4 share pin b: 0/4, 1/5, 2/6 and 3/7
    for (int b = 0; b < nand_tgt_pkg::NUM_BUSY; b++) begin
      pin_oe_d[b] = !(timer_ready && i_lun_ready_status_bit[b] &&
                      i_lun_ready_status_bit[b + 4]); // RQ9
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_oe_q <= 1'b1;
      pin_oe_q <= '1;
    end else begin
      busy_oe_q <= busy_oe_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign o_busy_oe = busy_oe_q;
  assign o_busy_out = 1'b0; // RQ10
  assign o_busy_pin_oe = pin_oe_q;
  assign o_busy_pin_out = '0; // RQ10
  assign o_low_power = low_power_q;
  assign o_cmd = cmd_q;
  assign o_cmd_valid = cmd_valid_q;
  assign o_addr = addr_q;
  assign o_addr_valid = addr_valid_q;
  assign o_data = data_q;
  assign o_data_valid = data_valid_q;
  assign o_array_op_allowed = allowed_q;
  assign o_op_refused = refused_q;

endmodule

//--- verification/nand_tgt_checker.sv
// Checker for busy, protect, bus-width and low-power behaviour at the block's ports
module nand_tgt_checker #(
  parameter int LUNS = 2,
  parameter bit WIDE_BUS = 1'b0,
  parameter int READY_CYC = 16
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [7:0] i_lun_ready_status_bit,
  input wire logic [LUNS-1:0] i_unit_ready,
  input wire logic i_cmd_strobe,
  input wire logic i_addr_strobe,
  input wire logic i_data_strobe,
  input wire logic [15:0] i_bus,
  input wire logic [3:0] o_busy_pin_oe,
  input wire logic o_busy_oe,
  input wire logic o_low_power,
  input wire logic [7:0] o_cmd,
  input wire logic o_cmd_valid,
  input wire logic [7:0] o_addr,
  input wire logic o_addr_valid,
  input wire logic [15:0] o_data,
  input wire logic o_data_valid,
  input wire logic o_array_op_allowed,
  input wire logic o_op_refused
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic pe;
  // Cycles since reset release, saturating
  always_comb cnt_d = (cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01;
  always_ff @(posedge i_clock or negedge i_rst_b)
    if (!i_rst_b) cnt_q <= 8'h00;
    else cnt_q <= cnt_d;
  assign pe = i_cmd_strobe && (i_bus[7:0] == 8'h80 || i_bus[7:0] == 8'h60);
  property p_cmd; i_cmd_strobe && !pe |=> o_cmd_valid && o_cmd == $past(i_bus[7:0]); endproperty
  a_cmd: assert property (p_cmd) else $error("command low byte wrong");
  property p_addr; i_addr_strobe && !i_cmd_strobe |=> o_addr_valid && o_addr == $past(i_bus[7:0]); endproperty
  a_addr: assert property (p_addr) else $error("address low byte wrong");
  property p_data; i_data_strobe && !i_cmd_strobe && !i_addr_strobe |=> o_data_valid &&
    o_data == (WIDE_BUS ? $past(i_bus) : {8'h00, $past(i_bus[7:0])}); endproperty
  a_data: assert property (p_data) else $error("data word wrong");
  property p_refuse; pe && !o_array_op_allowed |=> o_op_refused && !o_cmd_valid; endproperty
  a_refuse: assert property (p_refuse) else $error("protected operation not refused");
  property p_early; cnt_q < 8'h08 |-> o_busy_oe; endproperty
  a_early: assert property (p_early) else $error("busy released too early");
  property p_and; cnt_q > READY_CYC + 2 |-> o_busy_oe == !(&$past(i_unit_ready)); endproperty
  a_and: assert property (p_and) else $error("busy not AND of units");
  property p_pins; cnt_q > READY_CYC + 2 |-> o_busy_pin_oe ==
    ~($past(i_lun_ready_status_bit[3:0]) & $past(i_lun_ready_status_bit[7:4])); endproperty
  a_pins: assert property (p_pins) else $error("shared busy pin wrong");
  property p_lp; i_cmd_strobe && i_bus[7:0] == 8'hff |=> !o_low_power; endproperty
  a_lp: assert property (p_lp) else $error("low power kept after reset command");
  c_ref: cover property (pe && !o_array_op_allowed);
  c_lp: cover property (o_low_power ##1 !o_low_power);
  c_rdy: cover property ($fell(o_busy_oe));
endmodule
bind nand_target_support nand_tgt_checker #(.LUNS(LUNS), .WIDE_BUS(WIDE_BUS),
  .READY_CYC(READY_CYC)) i_chk (.*);

//--- verification/host_model.sv
// Host-side model: pull-up on the busy line and the hold-off before sampling it
module host_model #(
  parameter int HOLD_CYC = 10
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_busy_oe,
  output logic o_ready_line,
  output logic o_may_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_q;
  assign o_ready_line = i_busy_oe ? 1'b0 : 1'b1;
  assign o_may_sample = (wait_q >= HOLD_CYC);
  always_ff @(posedge i_clock or negedge i_rst_b)
    if (!i_rst_b) wait_q <= 0;
    else if (!o_may_sample) wait_q <= wait_q + 1;
endmodule

//--- verification/tb_top.sv
// Testbench for the target support block with a host-side model
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int READY = 16;
  localparam int SETTLE = 4;
  logic clock = 1'b0;
  logic rst_b, wp_b, cs, as, ds, busy_oe, lp, cv, av, dv, allowed, refused, line, may;
  logic [7:0] logical_unit, cmd, addr;
  logic [1:0] unit;
  logic [3:0] pin_oe;
  logic [15:0] bus, data;
  int bad_count = 0;
  int num_checks = 0;
  always #2.5 clock = ~clock;
  nand_target_support #(.LUNS(2), .WIDE_BUS(1'b1), .VALID_CYC(4), .READY_CYC(READY)) i_dut (
    .i_clock(clock), .i_rst_b(rst_b), .i_wp_b(wp_b), .i_lun_ready_status_bit(logical_unit),
    .i_unit_ready(unit), .i_cmd_strobe(cs), .i_addr_strobe(as), .i_data_strobe(ds),
    .i_bus(bus), .o_busy_pin_oe(pin_oe), .o_busy_pin_out(), .o_busy_oe(busy_oe),
    .o_busy_out(), .o_low_power(lp), .o_cmd(cmd), .o_cmd_valid(cv), .o_addr(addr),
    .o_addr_valid(av), .o_data(data), .o_data_valid(dv), .o_array_op_allowed(allowed),
    .o_op_refused(refused));
  host_model i_host (.i_clock(clock), .i_rst_b(rst_b), .i_busy_oe(busy_oe),
    .o_ready_line(line), .o_may_sample(may));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One strobe cycle; returns in the cycle where the answer stands
  task automatic xfer(input int kind, input logic [15:0] val);
    @(posedge clock);
    cs <= (kind == 0);
    as <= (kind == 1);
    ds <= (kind == 2);
    bus <= val;
    @(posedge clock);
    cs <= 1'b0;
    as <= 1'b0;
    ds <= 1'b0;
    bus <= ~val;
    #1;
  endtask
  task automatic t_power();
    chk("busy at start", 16'h0001, 16'(busy_oe));
    chk("low power", 16'h0001, 16'(lp));
    repeat (READY + 4) @(posedge clock);
    #1;
    chk("hold-off over", 16'h0001, 16'(may));
    chk("line ready", 16'h0001, 16'(line));
  endtask
  task automatic t_bus();
    xfer(0, 16'h5aff);
    chk("cmd", 16'h00ff, 16'(cmd));
    chk("low power exit", 16'h0000, 16'(lp));
    xfer(1, 16'h0034);
    chk("addr", 16'h0034, 16'(addr));
    chk("addr valid", 16'h0001, 16'(av));
    xfer(2, 16'hbeef);
    chk("data", 16'hbeef, data);
    chk("data valid", 16'h0001, 16'(dv));
  endtask
  task automatic t_wp();
    @(posedge clock);
    wp_b <= 1'b0;
    repeat (SETTLE) @(posedge clock);
    #1;
    chk("protect seen", 16'h0000, 16'(allowed));
    xfer(0, 16'h0080);
    chk("prog refused", 16'h0001, 16'(refused));
    chk("no prog", 16'h0000, 16'(cv));
    xfer(0, 16'h0060);
    chk("erase refused", 16'h0001, 16'(refused));
    @(posedge clock);
    wp_b <= 1'b1;
    repeat (SETTLE) @(posedge clock);
    #1;
    chk("protect lifted", 16'h0001, 16'(allowed));
    xfer(0, 16'h0060);
    chk("erase taken", 16'h0001, 16'(cv));
  endtask
  task automatic t_busy();
    @(posedge clock);
    unit <= 2'b01;
    logical_unit <= 8'hef;
    repeat (3) @(posedge clock);
    #1;
    chk("one unit busy", 16'h0001, 16'(busy_oe));
    chk("line low", 16'h0000, 16'(line));
    chk("pin 0 busy", 16'h0001, 16'(pin_oe));
    @(posedge clock);
    unit <= 2'b11;
    logical_unit <= 8'hfb;
    repeat (3) @(posedge clock);
    #1;
    chk("all ready", 16'h0000, 16'(busy_oe));
    chk("pin 2 busy", 16'h0004, 16'(pin_oe));
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    wp_b = 1'b1;
    {cs, as, ds} = 3'b000;
    logical_unit = 8'hff;
    unit = 2'b11;
    bus = 16'h0000;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    #1;
    t_power();
    t_bus();
    t_wp();
    t_busy();
    give_verdict();
  end
  // Whole run is under 200 cycles; cut a hang at 4000
  initial begin
    #20000;
    bad_count++;
    give_verdict();
  end
endmodule
